// File: angs_defs.svh
/*
 * Constants of the angle sensor serial slave: timing, frame layout,
 * commands, register numbers and factory defaults.
 * Assumes a 100 MHz system clock; included by bare name.
 */
`ifndef ANGS_DEFS_SVH
`define ANGS_DEFS_SVH

`define ANGS_CLK_NS 10
`define ANGS_REFRESH_NS 1000
`define ANGS_REFRESH_CYC (`ANGS_REFRESH_NS / `ANGS_CLK_NS)
`define ANGS_DIV_W 7
`define ANGS_NVM_WAIT_MS 20
`define ANGS_NVM_WAIT_CYC (`ANGS_NVM_WAIT_MS * 1000000 / `ANGS_CLK_NS)
`define ANGS_NVM_CNT_W 21

`define ANGS_FRAME_BITS 16
`define ANGS_CNT_W 5
`define ANGS_ANGLE_BITS 12
`define ANGS_PAD_BITS 4
`define ANGS_CMD_HI 15
`define ANGS_CMD_LO 13
`define ANGS_ADDR_HI 12
`define ANGS_ADDR_LO 8
`define ANGS_VAL_HI 7
`define ANGS_VAL_LO 0
`define ANGS_CMD_READ 3'h2
`define ANGS_CMD_WRITE 3'h4

`define ANGS_NREGS 32
`define ANGS_REG_LAST 5'h1f
`define ANGS_REG_DIR 5'h09
`define ANGS_REG_FIELD 5'h1b
`define ANGS_DIR_BIT 7
`define ANGS_REG4 5'h04
`define ANGS_REG5 5'h05
`define ANGS_REG6 5'h06
`define ANGS_DEF_REG4 8'hc0
`define ANGS_DEF_REG5 8'h3f
`define ANGS_DEF_REG6 8'h1c
`define ANGS_DEF_OTHER 8'h00

`endif

// File: angs_pkg.sv
/*
 * Types shared by the angle sensor serial slave and its register store.
 * Assumes nothing of its surroundings.
 */
package angs_pkg;
    typedef logic [7:0] angs_byte_t;
    typedef enum logic [1:0] {
        ANGS_ST_IDLE = 2'b01,
        ANGS_ST_FRAME = 2'b10
    } angs_link_e;
    typedef enum logic [2:0] {
        ANGS_NV_LOAD = 3'b001,
        ANGS_NV_IDLE = 3'b010,
        ANGS_NV_BUSY = 3'b100
    } angs_nvm_e;
endpackage : angs_pkg

// File: angs_nvm_if.sv
/*
 * Connection between the serial slave and its non-volatile register store.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface angs_nvm_if;
    logic wr_req;
    logic [4:0] wr_addr;
    angs_pkg::angs_byte_t wr_data;
    logic [4:0] rd_addr;
    angs_pkg::angs_byte_t rd_data;
    logic busy;
    logic dir_ccw;
    modport link (output wr_req, wr_addr, wr_data, rd_addr,
                  input rd_data, busy, dir_ccw);
    modport store (input wr_req, wr_addr, wr_data, rd_addr,
                   output rd_data, busy, dir_ccw);
endinterface : angs_nvm_if
`default_nettype wire

// File: angs_nvm.sv
/*
 * Non-volatile register store: 32 bytes, a timed commit per write to any register but 27, and a
 * load walk after reset that fills a blank part with factory defaults.
 * Assumes write requests are one-cycle pulses on the system clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "angs_defs.svh"
module angs_nvm #(
    parameter int WAIT_CYC = `ANGS_NVM_WAIT_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic nvm_blank_in,
    angs_nvm_if.store nvm_io
);
    angs_pkg::angs_byte_t mem [`ANGS_NREGS];
    angs_pkg::angs_nvm_e st_q, st_d;
    logic [4:0] ptr_q, ptr_d, addr_q, addr_d;
    angs_pkg::angs_byte_t data_q, data_d, wdata;
    logic [`ANGS_NVM_CNT_W-1:0] cnt_q, cnt_d;
    logic blank_s1_q, blank_s2_q, we, commit;
    logic [4:0] waddr;

    function automatic angs_pkg::angs_byte_t factory(input logic [4:0] a);
        unique case (a)
            `ANGS_REG4: factory = `ANGS_DEF_REG4;
            `ANGS_REG5: factory = `ANGS_DEF_REG5;
            `ANGS_REG6: factory = `ANGS_DEF_REG6;
            default: factory = `ANGS_DEF_OTHER;
        endcase
    endfunction : factory

    // Readback shows the stored byte, so an early ack frame sees the old one.
    assign nvm_io.rd_data = mem[nvm_io.rd_addr];
    assign nvm_io.dir_ccw = mem[`ANGS_REG_DIR][`ANGS_DIR_BIT];
    assign nvm_io.busy = (st_q != angs_pkg::ANGS_NV_IDLE);
    assign commit = (st_q == angs_pkg::ANGS_NV_BUSY) &&
                    (cnt_q == `ANGS_NVM_CNT_W'(WAIT_CYC - 1));

    always_comb
    begin
        st_d = st_q;
        ptr_d = ptr_q;
        addr_d = addr_q;
        data_d = data_q;
        cnt_d = cnt_q;
        we = 1'b0;
        waddr = addr_q;
        wdata = data_q;
        unique case (st_q)
            angs_pkg::ANGS_NV_LOAD:
            begin
                // The store keeps its bytes across reset; only a blank part
                // is filled with defaults.
                we = blank_s2_q;
                waddr = ptr_q;
                wdata = factory(ptr_q);
                ptr_d = ptr_q + 5'h01;
                if (ptr_q == `ANGS_REG_LAST)
                    st_d = angs_pkg::ANGS_NV_IDLE;
            end
            angs_pkg::ANGS_NV_IDLE:
            begin
                if (nvm_io.wr_req && nvm_io.wr_addr != `ANGS_REG_FIELD)
                begin
                    addr_d = nvm_io.wr_addr;
                    data_d = nvm_io.wr_data;
                    cnt_d = '0;
                    st_d = angs_pkg::ANGS_NV_BUSY;
                end
            end
            angs_pkg::ANGS_NV_BUSY:
            begin
                cnt_d = cnt_q + `ANGS_NVM_CNT_W'(1);
                if (commit)
                begin
                    we = 1'b1;
                    st_d = angs_pkg::ANGS_NV_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        blank_s1_q <= nvm_blank_in;
        blank_s2_q <= blank_s1_q;
        if (we)
            mem[waddr] <= wdata;
        if (!rstn_in)
        begin
            st_q <= angs_pkg::ANGS_NV_LOAD;
            ptr_q <= 5'h00;
            addr_q <= 5'h00;
            data_q <= 8'h00;
            cnt_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            ptr_q <= ptr_d;
            addr_q <= addr_d;
            data_q <= data_d;
            cnt_q <= cnt_d;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    chk_commit_value: assert property (
        commit |=> mem[$past(addr_q)] == $past(data_q))
        else $error("committed byte differs from written byte");
    chk_wait_holds: assert property (
        (st_q == angs_pkg::ANGS_NV_BUSY) && !commit
        |=> mem[addr_q] == $past(mem[addr_q]))
        else $error("byte changed before the write delay ended");
    chk_load_walk: assert property (
        (st_q == angs_pkg::ANGS_NV_LOAD) && (ptr_q != `ANGS_REG_LAST)
        |=> st_q == angs_pkg::ANGS_NV_LOAD)
        else $error("load walk ended early");
endmodule : angs_nvm
`default_nettype wire

// File: angs_spi_slave.sv
/*
 * Serial slave port of a contactless angle sensor: angle reads from a
 * buffer refreshed every microsecond, two-frame register reads and
 * two-frame register writes into a non-volatile store.
 * Assumes the link pins are asynchronous to clk_sys_in and that angle and
 * field flags come from front-end logic on clk_sys_in.
 */
// What this block does
// - Accept modes 0 and 3, detected automatically.
// - Serial clock up to 25 MHz, no minimum.
// - Sample rising, launch falling, MSB first, select idles high.
// - Refresh angle buffer every microsecond unless frozen.
// - Select fall freezes buffer until select rises.
// - Full angle read shifts 16 bits out.
// - Pad trailing bits beyond angle width with zeros.
// - Tolerate angle reads truncated by the master.
// - Fast reads repeat the same angle until refresh.
// - Next frame returns register byte, then zeros.
// - First register frame still shifts out the angle.
// - Next frame after write returns stored value.
// - Write takes 20 ms; earlier readback gives old.
// - Keep writes non-volatile, reload them at power-on.
// - Register 27 returns field high and low flags.
// - Register 9 top bit selects counterclockwise direction.
`timescale 1ns/100ps
`default_nettype none
`include "angs_defs.svh"
module angs_spi_slave #(
    parameter int NVM_WAIT_CYC = `ANGS_NVM_WAIT_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_out,
    input wire logic [`ANGS_ANGLE_BITS-1:0] angle_in,
    input wire logic field_high_flag_in,
    input wire logic field_low_flag_in,
    input wire logic nvm_blank_in,
    output logic rot_ccw_out
);
    localparam int NPIN = 3;
    localparam int P_CS = 2;
    localparam int P_SCLK = 1;
    localparam int P_MOSI = 0;
    localparam int REFRESH_CYC = `ANGS_REFRESH_CYC;

    angs_nvm_if nvm_bus ();

    angs_nvm #(
        .WAIT_CYC(NVM_WAIT_CYC)
    ) u_nvm (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .nvm_blank_in(nvm_blank_in),
        .nvm_io(nvm_bus.store)
    );

    // Pin synchronisers; the first stage feeds only the second.
    logic [NPIN-1:0] pins;
    logic [NPIN-1:0] s1_q, s2_q, s3_q;
    assign pins = {cs_n_in, sclk_in, mosi_in};

    generate
        for (genvar i = 0; i < NPIN; i++)
        begin : g_sync
            always_ff @(posedge clk_sys_in)
            begin
                if (!rstn_in)
                begin
                    s1_q[i] <= (i == P_CS) ? 1'b1 : 1'b0;
                    s2_q[i] <= (i == P_CS) ? 1'b1 : 1'b0;
                    s3_q[i] <= (i == P_CS) ? 1'b1 : 1'b0;
                end
                else
                begin
                    s1_q[i] <= pins[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                end
            end
        end
    endgenerate

    // Edges are found by oversampling, so any slow serial clock works;
    // at the 25 MHz limit each phase still spans two system cycles.
    logic cs_fall, cs_rise, sclk_rise, sclk_fall, mosi_bit;
    assign cs_fall = s3_q[P_CS] & ~s2_q[P_CS];
    assign cs_rise = ~s3_q[P_CS] & s2_q[P_CS];
    assign sclk_rise = ~s3_q[P_SCLK] & s2_q[P_SCLK];
    assign sclk_fall = s3_q[P_SCLK] & ~s2_q[P_SCLK];
    assign mosi_bit = s2_q[P_MOSI];

    angs_pkg::angs_link_e st_q, st_d;
    logic [`ANGS_FRAME_BITS-1:0] tx_q, tx_d, rx_q, rx_d, abuf_q, abuf_d;
    logic [`ANGS_CNT_W-1:0] cnt_q, cnt_d;
    logic [`ANGS_DIV_W-1:0] div_q, div_d;
    logic skip_q, skip_d, pend_q, pend_d, oe_q, oe_d;
    logic [4:0] pend_addr_q, pend_addr_d, wr_addr_q, wr_addr_d;
    angs_pkg::angs_byte_t wr_data_q, wr_data_d, rdval;
    logic wr_req_q, wr_req_d, rot_q, rot_d, refresh, full;
    logic [2:0] cmd;
    logic [4:0] addr;

    assign refresh = (div_q == `ANGS_DIV_W'(`ANGS_REFRESH_CYC - 1));
    assign full = (cnt_q == `ANGS_CNT_W'(`ANGS_FRAME_BITS));
    assign cmd = rx_q[`ANGS_CMD_HI:`ANGS_CMD_LO];
    assign addr = rx_q[`ANGS_ADDR_HI:`ANGS_ADDR_LO];

    // The field register is live status, not a stored byte.
    assign rdval = (pend_addr_q == `ANGS_REG_FIELD) ?
        {field_high_flag_in, field_low_flag_in, 6'h00} :
        nvm_bus.rd_data;

    assign nvm_bus.rd_addr = pend_addr_q;
    assign nvm_bus.wr_req = wr_req_q;
    assign nvm_bus.wr_addr = wr_addr_q;
    assign nvm_bus.wr_data = wr_data_q;

    assign miso_out = tx_q[`ANGS_FRAME_BITS-1];
    assign miso_oe_out = oe_q;
    assign rot_ccw_out = rot_q;

    always_comb
    begin
        st_d = st_q;
        tx_d = tx_q;
        rx_d = rx_q;
        cnt_d = cnt_q;
        skip_d = skip_q;
        pend_d = pend_q;
        pend_addr_d = pend_addr_q;
        oe_d = oe_q;
        wr_req_d = 1'b0;
        wr_addr_d = wr_addr_q;
        wr_data_d = wr_data_q;
        rot_d = nvm_bus.dir_ccw;
        div_d = refresh ? '0 : div_q + `ANGS_DIV_W'(1);
        abuf_d = abuf_q;
        // A held buffer is skipped, so fast reads see the same angle.
        if (refresh && st_q == angs_pkg::ANGS_ST_IDLE)
            abuf_d = {angle_in, {`ANGS_PAD_BITS{1'b0}}};
        unique case (st_q)
            angs_pkg::ANGS_ST_IDLE:
            begin
                if (cs_fall)
                begin
                    st_d = angs_pkg::ANGS_ST_FRAME;
                    cnt_d = '0;
                    oe_d = 1'b1;
                    // Clock high at select fall means mode 3; its first
                    // falling edge launches the bit already on the line.
                    skip_d = s2_q[P_SCLK];
                    tx_d = pend_q ? {rdval, 8'h00} : abuf_q;
                end
            end
            angs_pkg::ANGS_ST_FRAME:
            begin
                if (cs_rise)
                begin
                    st_d = angs_pkg::ANGS_ST_IDLE;
                    oe_d = 1'b0;
                    pend_d = 1'b0;
                    // A cut frame is a plain angle read and is dropped.
                    if (full)
                    begin
                        if (cmd == `ANGS_CMD_READ)
                        begin
                            pend_d = 1'b1;
                            pend_addr_d = addr;
                        end
                        else if (cmd == `ANGS_CMD_WRITE)
                        begin
                            pend_d = 1'b1;
                            pend_addr_d = addr;
                            wr_req_d = ~nvm_bus.busy;
                            wr_addr_d = addr;
                            wr_data_d = rx_q[`ANGS_VAL_HI:`ANGS_VAL_LO];
                        end
                    end
                end
                else
                begin
                    if (sclk_rise && !full)
                    begin
                        rx_d = {rx_q[`ANGS_FRAME_BITS-2:0], mosi_bit};
                        cnt_d = cnt_q + `ANGS_CNT_W'(1);
                    end
                    if (sclk_fall)
                    begin
                        if (skip_q)
                            skip_d = 1'b0;
                        else
                            tx_d = {tx_q[`ANGS_FRAME_BITS-2:0], 1'b0};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            st_q <= angs_pkg::ANGS_ST_IDLE;
            tx_q <= '0;
            rx_q <= '0;
            cnt_q <= '0;
            skip_q <= 1'b0;
            pend_q <= 1'b0;
            pend_addr_q <= 5'h00;
            oe_q <= 1'b0;
            wr_req_q <= 1'b0;
            wr_addr_q <= 5'h00;
            wr_data_q <= 8'h00;
            rot_q <= 1'b0;
            div_q <= '0;
            abuf_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            cnt_q <= cnt_d;
            skip_q <= skip_d;
            pend_q <= pend_d;
            pend_addr_q <= pend_addr_d;
            oe_q <= oe_d;
            wr_req_q <= wr_req_d;
            wr_addr_q <= wr_addr_d;
            wr_data_q <= wr_data_d;
            rot_q <= rot_d;
            div_q <= div_d;
            abuf_q <= abuf_d;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    sequence s_frame_start;
        (st_q == angs_pkg::ANGS_ST_IDLE) && cs_fall;
    endsequence
    sequence s_frame_end;
        (st_q == angs_pkg::ANGS_ST_FRAME) && cs_rise;
    endsequence
    sequence s_live_fall;
        (st_q == angs_pkg::ANGS_ST_FRAME) && !cs_rise && sclk_fall &&
            !skip_q;
    endsequence
    sequence s_live_rise;
        (st_q == angs_pkg::ANGS_ST_FRAME) && !cs_rise && sclk_rise;
    endsequence
    sequence s_dummy_fall;
        (st_q == angs_pkg::ANGS_ST_FRAME) && !cs_rise && sclk_fall &&
            skip_q;
    endsequence

    // Pin edges are judged from the synchronised copies, the same view
    // that the logic acts on, so a late sample cannot split the two.

    chk_buf_frozen: assert property (
        (st_q == angs_pkg::ANGS_ST_FRAME) |=> $stable(abuf_q))
        else $error("angle buffer changed during a frame");
    chk_buf_refresh: assert property (
        refresh && (st_q == angs_pkg::ANGS_ST_IDLE) |=>
        abuf_q[`ANGS_FRAME_BITS-1:`ANGS_PAD_BITS] == $past(angle_in))
        else $error("idle buffer missed its refresh");
    chk_pad_zero: assert property (
        abuf_q[`ANGS_PAD_BITS-1:0] == '0)
        else $error("padding bits of the angle not zero");
    chk_angle_load: assert property (
        s_frame_start and !pend_q |=> tx_q == $past(abuf_q) && oe_q)
        else $error("angle frame did not load the buffer");
    chk_reg_reply: assert property (
        s_frame_start and pend_q |=>
        tx_q == {$past(rdval), 8'h00})
        else $error("register reply not byte then zeros");
    chk_mode3_skip: assert property (
        s_dummy_fall |=> $stable(tx_q) && !skip_q)
        else $error("mode 3 first falling edge shifted data");
    chk_shift_msb: assert property (
        s_live_fall |=>
        tx_q == {$past(tx_q[`ANGS_FRAME_BITS-2:0]), 1'b0})
        else $error("falling edge did not advance the output");
    chk_cut_frame: assert property (
        s_frame_end and !full |=> !pend_q && !wr_req_q)
        else $error("incomplete frame was acted upon");
    chk_write_req: assert property (
        s_frame_end and full && (cmd == `ANGS_CMD_WRITE) |=>
        pend_q && pend_addr_q == $past(addr) &&
        wr_data_q == $past(rx_q[`ANGS_VAL_HI:`ANGS_VAL_LO]))
        else $error("write request not latched for acknowledge");
    chk_field_flags: assert property (
        s_frame_start and pend_q && (pend_addr_q == `ANGS_REG_FIELD) |=>
        tx_q[`ANGS_FRAME_BITS-1:`ANGS_FRAME_BITS-8] ==
        {$past(field_high_flag_in), $past(field_low_flag_in), 6'h00})
        else $error("field register does not show the flags");
    // The store is unknown on a blank part until its load walk is over,
    // so only a settled store is compared.
    chk_dir_follow: assert property (
        !nvm_bus.busy |=> rot_ccw_out == $past(nvm_bus.dir_ccw))
        else $error("direction output lags the stored bit");
    chk_oe_window: assert property (
        s_frame_end |=> !miso_oe_out ##1 !miso_oe_out)
        else $error("data output still driven after deselect");
    chk_mosi_capture: assert property (
        s_live_rise and !full |=>
        rx_q[0] == $past(mosi_bit) &&
        cnt_q == $past(cnt_q) + `ANGS_CNT_W'(1))
        else $error("rising edge did not capture the input bit");
    chk_read_req: assert property (
        s_frame_end and full && (cmd == `ANGS_CMD_READ) |=>
        pend_q && pend_addr_q == $past(addr) && !wr_req_q)
        else $error("read request not latched for reply");
    chk_plain_clear: assert property (
        s_frame_end and full && (cmd != `ANGS_CMD_READ) &&
        (cmd != `ANGS_CMD_WRITE) |=> !pend_q)
        else $error("plain frame left a reply pending");
    chk_oe_held: assert property (
        (st_q == angs_pkg::ANGS_ST_FRAME) && !cs_rise |=> miso_oe_out)
        else $error("data output released inside a frame");
    chk_oe_idle: assert property (
        (st_q == angs_pkg::ANGS_ST_IDLE) && !cs_fall |=> !miso_oe_out)
        else $error("data output driven while deselected");
    chk_idle_ignore: assert property (
        (st_q == angs_pkg::ANGS_ST_IDLE) && !cs_fall |=>
        $stable(tx_q) && $stable(rx_q))
        else $error("clock edges acted on while deselected");
    chk_refresh_rate: assert property (
        refresh |-> ##REFRESH_CYC refresh)
        else $error("angle refresh period is wrong");
    chk_write_pulse: assert property (
        wr_req_q |=> !wr_req_q)
        else $error("store write request longer than one cycle");
endmodule : angs_spi_slave
`default_nettype wire

// File: angs_master_model.sv
/*
 * Behavioural serial master that faces the angle sensor slave port.
 * Assumes a 125 ns link clock and a slave that samples the link pins
 * with its own 100 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
module angs_master_model (
    output logic cs_n_out,
    output logic sclk_out,
    output logic mosi_out,
    input wire logic miso_in,
    input wire logic miso_oe_in
);
    localparam real HALF = 62.5;
    logic miso_pin;

    // A released data line is pulled low, so stale bits never look valid.
    assign miso_pin = miso_oe_in ? miso_in : 1'b0;

    initial
    begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        mosi_out = 1'b0;
    end

    // Sending fewer than 16 bits ends the frame early on purpose.
    task automatic xfer(input logic cpol, input int nbits,
                        input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        sclk_out = cpol;
        #(HALF);
        cs_n_out = 1'b0;
        #100;
        for (int i = 0; i < nbits; i++)
        begin
            sclk_out = 1'b0;
            mosi_out = tx[15-i];
            #(HALF);
            rx[15-i] = miso_pin;
            sclk_out = 1'b1;
            #(HALF);
        end
        if (!cpol)
        begin
            sclk_out = 1'b0;
        end
        #(HALF);
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
        #200;
    endtask : xfer
endmodule : angs_master_model
`default_nettype wire

// File: tb_top.sv
/*
 * Self-checking bench for the angle sensor serial slave.
 * Assumes the master model drives the link and a short commit delay.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int NVM_WAIT = 400;
    localparam int LONG_NS = NVM_WAIT * 10 + 1000;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic [11:0] angle = 12'h000;
    logic fh = 1'b0;
    logic fl = 1'b0;
    logic blank = 1'b1;
    logic rot_ccw;
    logic [15:0] rx;
    int error_cnt = 0;
    int total_checks = 0;

    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    angs_spi_slave #(.NVM_WAIT_CYC(NVM_WAIT)) dut (
        .clk_sys_in(clk_sys), .rstn_in(rstn), .cs_n_in(cs_n),
        .sclk_in(sclk), .mosi_in(mosi), .miso_out(miso),
        .miso_oe_out(miso_oe), .angle_in(angle),
        .field_high_flag_in(fh), .field_low_flag_in(fl),
        .nvm_blank_in(blank), .rot_ccw_out(rot_ccw)
    );

    angs_master_model master (
        .cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi),
        .miso_in(miso), .miso_oe_in(miso_oe)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Three edges of reset let the strap synchroniser settle.
    task automatic do_reset(input logic fill);
        @(posedge clk_sys);
        blank <= fill;
        rstn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (250) @(posedge clk_sys);
    endtask : do_reset

    // Request frame, gap, then the reply frame; the angle is held steady.
    task automatic reg_op(input logic [2:0] cmd, input logic [4:0] addr,
                          input logic [7:0] val, input int gap_ns,
                          input logic [7:0] exp);
        master.xfer(1'b0, 16, {cmd, addr, val}, rx);
        chk(rx, {angle, 4'h0});
        #(gap_ns);
        master.xfer(1'b0, 16, 16'h0000, rx);
        chk(rx, {exp, 8'h00});
        #750;
    endtask : reg_op

    task automatic t_modes();
        @(posedge clk_sys);
        angle <= 12'ha5c;
        #1500;
        master.xfer(1'b0, 16, 16'h0000, rx);
        chk(rx, 16'ha5c0);
        master.xfer(1'b1, 16, 16'h0000, rx);
        chk(rx, 16'ha5c0);
        $display("test modes done");
    endtask : t_modes

    task automatic t_freeze();
        @(posedge clk_sys);
        angle <= 12'h3c1;
        #1500;
        fork
            master.xfer(1'b0, 16, 16'h0000, rx);
            begin
                #400;
                @(posedge clk_sys);
                angle <= 12'h7e2;
            end
        join
        chk(rx, 16'h3c10);
        #1200;
        master.xfer(1'b0, 12, 16'h0000, rx);
        chk(rx, 16'h7e20);
        $display("test freeze done");
    endtask : t_freeze

    task automatic t_reg_read();
        logic [4:0] addrs [4];
        logic [7:0] vals [4];
        addrs = '{5'h04, 5'h05, 5'h06, 5'h00};
        vals = '{8'hc0, 8'h3f, 8'h1c, 8'h00};
        #750;
        for (int i = 0; i < 4; i++)
        begin
            reg_op(3'h2, addrs[i], 8'h00, 750, vals[i]);
        end
        @(posedge clk_sys);
        fh <= 1'b1;
        reg_op(3'h2, 5'h1b, 8'h00, 750, 8'h80);
        @(posedge clk_sys);
        fh <= 1'b0;
        fl <= 1'b1;
        reg_op(3'h2, 5'h1b, 8'h00, 750, 8'h40);
        $display("test register read done");
    endtask : t_reg_read

    task automatic t_write();
        reg_op(3'h4, 5'h04, 8'h12, 750, 8'hc0);
        #(LONG_NS);
        reg_op(3'h2, 5'h04, 8'h00, 750, 8'h12);
        reg_op(3'h4, 5'h09, 8'h80, LONG_NS, 8'h80);
        chk({15'h0000, rot_ccw}, 16'h0001);
        $display("test write done");
    endtask : t_write

    // A request cut short by select must leave no reply pending.
    // Fifteen bits leave a read command on top of the shifter, so only
    // the bit count can refuse it.
    task automatic t_short_cmd();
        master.xfer(1'b0, 15, {2'b10, 5'h05, 9'h000}, rx);
        #750;
        master.xfer(1'b0, 16, 16'h0000, rx);
        chk(rx, {angle, 4'h0});
        $display("test short command done");
    endtask : t_short_cmd

    task automatic t_keep();
        do_reset(1'b0);
        chk({15'h0000, rot_ccw}, 16'h0001);
        reg_op(3'h2, 5'h04, 8'h00, 750, 8'h12);
        $display("test keep done");
    endtask : t_keep

    initial
    begin
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (250) @(posedge clk_sys);
        t_modes();
        t_freeze();
        t_reg_read();
        t_write();
        t_short_cmd();
        t_keep();
        report_and_stop();
    end

    // The whole sequence needs well under 200 us.
    initial
    begin
        #500000;
        error_cnt++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
